// ===== core/rss_reset_source_sequencer.sv
// Purpose: Reset source sequencer with AXI4-Lite status and control
// Assumes: power_on_reset_n arrives asynchronously and is synchronised here
// Notes:   Pin and strap inputs pass two flops before use
//
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module rss_reset_source_sequencer #(
    parameter logic [2:0] SCAN_EXTEST = 3'h0,
    parameter logic [2:0] SCAN_CLAMP  = 3'h1,
    parameter logic [2:0] SCAN_HIGHZ  = 3'h2
) (
    // Clock and bus reset
    input  wire logic               aclk,
    input  wire logic               aresetn,
    // Reset pins
    input  wire logic               power_on_reset_n,
    input  wire logic               hard_reset_n_in,
    output logic                    hard_reset_n_out,
    output logic                    hard_reset_n_oe,
    // Internal sources
    input  wire logic               watchdog_expired,
    input  wire logic               bus_monitor_timeout,
    input  wire rss_pkg::rss_scan_t scan_cmd,
    // Straps
    input  wire rss_pkg::rss_straps_t straps,
    // Reset outputs
    output logic                    pll_reset,
    output logic                    watchdog_regs_reset,
    output logic                    clock_ctrl_reset,
    output logic                    core_reset,
    output logic                    periph_reset,
    output logic                    soft_reset_n,
    output rss_pkg::rss_straps_t    captured_straps,
    // AXI4-Lite
    input  wire logic [3:0]         s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [3:0]         s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready
);
    import rss_pkg::*;

    typedef struct packed {
        logic [1:0]  por_sync;
        logic [1:0]  hard_sync;
        logic [4:0]  straps_sync_a;
        logic [4:0]  straps_sync;
        logic        por_prev;
        rss_state_t  state;
        logic [9:0]  count;
        rss_straps_t cfg;
        logic        pll_rst;
        logic        drive_hard;
        logic [1:0]  drive_dly;
        logic        any_rst;
        logic        soft_act;
        logic        ctrl_hard;
        logic        ctrl_scan;
        logic [2:0]  hard_cnt;
        logic [2:0]  soft_cnt;
        logic        aw_got;
        logic        w_got;
        logic [3:0]  aw_addr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } rss_regs_t;

    rss_regs_t r;
    rss_regs_t next_r;
    logic       por_n;
    logic       ext_hard;
    logic       hard_src;
    logic       soft_src;

    function automatic logic is_scan_reset(input logic [2:0] ins);
        return (ins == SCAN_EXTEST) || (ins == SCAN_CLAMP) || (ins == SCAN_HIGHZ);
    endfunction

    assign por_n    = r.por_sync[1];
    // Our own pull is still in the synchroniser for two cycles after release
    assign ext_hard = !r.hard_sync[1] && !r.drive_hard && (r.drive_dly == 2'b00);
    // Pin, watchdog or bus monitor, or a software request
    assign hard_src = ext_hard || watchdog_expired || bus_monitor_timeout || r.ctrl_hard;
    assign soft_src = (scan_cmd.scan_exec && is_scan_reset(scan_cmd.scan_instr))
                      || r.ctrl_scan;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        next_r = r;
        next_r.por_sync = {r.por_sync[0], power_on_reset_n};
        next_r.hard_sync = {r.hard_sync[0], hard_reset_n_in};
        // Only the second strap stage feeds the capture
        next_r.straps_sync_a = straps;
        next_r.straps_sync = r.straps_sync_a;
        next_r.drive_dly = {r.drive_dly[0], r.drive_hard};
        next_r.por_prev = por_n;
        next_r.ctrl_hard = 1'b0;
        next_r.ctrl_scan = 1'b0;
        if (!por_n) begin
            // Power-on holds the pin and every reset output except soft_reset_n, including the PLL
            next_r.pll_rst    = 1'b1;
            next_r.drive_hard = 1'b1;
            next_r.any_rst    = 1'b1;
            next_r.soft_act   = 1'b0;
            next_r.state      = RSS_HARD;
            next_r.count      = HARD_DELAY;
        end else begin
            next_r.pll_rst = 1'b0;
            if (!r.por_prev) begin
                next_r.cfg = rss_straps_t'(r.straps_sync);
            end
            case (r.state)
                RSS_IDLE: begin
                    if (hard_src) begin
                        next_r.state      = RSS_HARD;
                        next_r.count      = HARD_DELAY;
                        next_r.drive_hard = 1'b1;
                        next_r.any_rst    = 1'b1;
                        next_r.hard_cnt   = r.hard_cnt + 3'h1;
                    end else if (soft_src) begin
                        next_r.state    = RSS_SOFT;
                        next_r.count    = SOFT_LEN;
                        next_r.soft_act = 1'b1;
                        next_r.any_rst  = 1'b1;
                        next_r.soft_cnt = r.soft_cnt + 3'h1;
                    end
                end
                RSS_HARD: begin
                    // Count 521 cycles from release, then let go of the pin
                    if (r.count == 10'd1) begin
                        next_r.state      = RSS_IDLE;
                        next_r.count      = 10'd0;
                        next_r.drive_hard = 1'b0;
                        next_r.any_rst    = 1'b0;
                    end else begin
                        next_r.count = r.count - 10'd1;
                    end
                end
                RSS_SOFT: begin
                    // Pin stays released; a hard source pre-empts
                    if (hard_src) begin
                        next_r.state      = RSS_HARD;
                        next_r.count      = HARD_DELAY;
                        next_r.drive_hard = 1'b1;
                        next_r.soft_act   = 1'b0;
                    end else if (r.count == 10'd1) begin
                        next_r.state    = RSS_IDLE;
                        next_r.count    = 10'd0;
                        next_r.soft_act = 1'b0;
                        next_r.any_rst  = 1'b0;
                    end else begin
                        next_r.count = r.count - 10'd1;
                    end
                end
                default: begin
                    next_r.state = RSS_IDLE;
                end
            endcase
        end

        // AXI4-Lite write path
        if (s_axi_awvalid && !r.aw_got) begin
            next_r.aw_got  = 1'b1;
            next_r.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !r.w_got) begin
            next_r.w_got = 1'b1;
            next_r.wdata = s_axi_wdata;
            next_r.wstrb = s_axi_wstrb;
        end
        if (r.aw_got && r.w_got && !r.bvalid) begin
            next_r.aw_got = 1'b0;
            next_r.w_got  = 1'b0;
            next_r.bvalid = 1'b1;
            next_r.bresp  = RESP_OKAY;
            if (r.aw_addr == ADDR_CTRL) begin
                if (r.wstrb[0]) begin
                    next_r.ctrl_hard = r.wdata[CTRL_HARD_REQ];
                    next_r.ctrl_scan = r.wdata[CTRL_SCAN_CMD];
                end
            end else if (r.aw_addr != ADDR_STATUS && r.aw_addr != ADDR_CONFIG
                         && r.aw_addr != ADDR_COUNT) begin
                next_r.bresp = RESP_SLVERR;
            end
        end
        if (r.bvalid && s_axi_bready) begin
            next_r.bvalid = 1'b0;
        end

        // AXI4-Lite read path
        if (s_axi_arvalid && !r.rvalid) begin
            next_r.rvalid = 1'b1;
            next_r.rresp  = RESP_OKAY;
            case (s_axi_araddr)
                ADDR_CTRL:   next_r.rdata = CTRL_RESET;
                ADDR_STATUS: next_r.rdata = {26'h0, r.state, r.soft_act,
                                             r.drive_hard, r.pll_rst, r.any_rst};
                ADDR_CONFIG: next_r.rdata = {27'h0, r.cfg};
                ADDR_COUNT:  next_r.rdata = {10'h0, r.soft_cnt, 5'h0, r.hard_cnt,
                                             1'b0, r.count};
                default: begin
                    next_r.rdata = 32'h0000_0000;
                    next_r.rresp = RESP_SLVERR;
                end
            endcase
        end else if (r.rvalid && s_axi_rready) begin
            next_r.rvalid = 1'b0;
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r          <= '0;
            r.hard_sync <= 2'b11;
            r.pll_rst  <= 1'b1;
            r.any_rst  <= 1'b1;
            r.drive_hard <= 1'b1;
            r.state    <= RSS_HARD;
            r.count    <= HARD_DELAY;
        end else begin
            r <= next_r;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // Open-drain: only ever pull low, pull-up releases the line
    assign hard_reset_n_out    = 1'b0;
    assign hard_reset_n_oe     = r.drive_hard;
    assign pll_reset           = r.pll_rst;
    assign watchdog_regs_reset = r.any_rst;
    assign clock_ctrl_reset    = r.any_rst;
    assign core_reset          = r.any_rst;
    assign periph_reset        = r.any_rst;
    assign soft_reset_n        = !r.soft_act;
    assign captured_straps     = r.cfg;
    // Configuration itself flows through the host port or I2C elsewhere
    assign s_axi_awready = !r.aw_got;
    assign s_axi_wready  = !r.w_got;
    assign s_axi_bvalid  = r.bvalid;
    assign s_axi_bresp   = r.bresp;
    assign s_axi_arready = !r.rvalid;
    assign s_axi_rvalid  = r.rvalid;
    assign s_axi_rdata   = r.rdata;
    assign s_axi_rresp   = r.rresp;
endmodule
`default_nettype wire

// ===== core/rss_pkg.sv
// Purpose: Shared constants and types for the reset source sequencer
// Assumes: Single 40 MHz clock domain
// Notes:   Register map is a local choice
package rss_pkg;
    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_CONFIG = 4'h8;
    localparam logic [3:0] ADDR_COUNT  = 4'hc;
    localparam int CTRL_HARD_REQ = 0;
    localparam int CTRL_SCAN_CMD = 1;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY  = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    // ************************************************************
    // Timing
    // ************************************************************
    localparam int POR_MIN_CYCLES     = 16;
    localparam int HARD_DELAY_CYCLES  = 521;
    localparam logic [9:0] HARD_DELAY = 10'd521;
    localparam logic [9:0] SOFT_LEN   = 10'd16;
    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        RSS_IDLE = 2'b00,
        RSS_HARD = 2'b01,
        RSS_SOFT = 2'b11
    } rss_state_t;
    typedef struct packed {
        logic [1:0] boot_mode_strap;
        logic       watchdog_enable_strap;
        logic       host_narrow_bus_strap;
        logic       host_config_strap;
    } rss_straps_t;
    typedef struct packed {
        logic [2:0] scan_instr;
        logic       scan_exec;
    } rss_scan_t;
endpackage

// ===== verification/rss_asserts.sv
// Purpose: Port checks for the reset source sequencer
// Assumes: One clock domain, synchronous reset
// Notes:   Windows allow for the pin synchronisers
`timescale 1ns/1ps
`default_nettype none
module rss_asserts (
    // Clock and reset
    input wire logic                 aclk,
    input wire logic                 aresetn,
    // Watched ports
    input wire logic                 power_on_reset_n,
    input wire logic                 hard_reset_n_oe,
    input wire logic                 pll_reset,
    input wire logic                 watchdog_regs_reset,
    input wire logic                 core_reset,
    input wire logic                 soft_reset_n,
    input wire rss_pkg::rss_scan_t   scan_cmd,
    input wire rss_pkg::rss_straps_t captured_straps
);
    import rss_pkg::*;
    logic [10:0] por_cnt;
    logic [10:0] drv_cnt;
    logic        por_seq;
    logic        idle;
    assign idle = soft_reset_n && !hard_reset_n_oe && power_on_reset_n;
    always_ff @(posedge aclk) begin
        por_cnt <= (aresetn && power_on_reset_n) ? por_cnt + 11'h1 : 11'h0;
        drv_cnt <= (aresetn && hard_reset_n_oe) ? drv_cnt + 11'h1 : 11'h0;
        por_seq <= !aresetn || !power_on_reset_n || (por_seq && hard_reset_n_oe);
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // A hard source may cut the soft pulse short
    sequence soft_hold;
        (!soft_reset_n || hard_reset_n_oe) [*8];
    endsequence
    a_soft_quiet: assert property (!soft_reset_n |-> !pll_reset && !hard_reset_n_oe)
        else $error("soft reset disturbed pll or pin");
    a_soft_resets: assert property (!soft_reset_n |-> core_reset && watchdog_regs_reset)
        else $error("soft reset missed a block");
    a_drive_resets: assert property (hard_reset_n_oe |-> core_reset && watchdog_regs_reset)
        else $error("hard reset missed a block");
    a_straps_held: assert property (
        !hard_reset_n_oe && !$past(hard_reset_n_oe) |-> $stable(captured_straps))
        else $error("straps changed outside power-on");
    a_scan_soft: assert property (
        scan_cmd.scan_exec && scan_cmd.scan_instr <= 3'h2 && idle |-> ##[1:3] !soft_reset_n)
        else $error("scan command gave no soft reset");
    a_soft_len: assert property ($fell(soft_reset_n) |-> soft_hold ##1 soft_hold ##1 soft_reset_n)
        else $error("soft reset length wrong");
    a_hard_len: assert property (
        $fell(hard_reset_n_oe) && !por_seq |-> drv_cnt >= 11'h207 && drv_cnt <= 11'h20b)
        else $error("hard reset length wrong");
    a_por_release: assert property (
        $fell(hard_reset_n_oe) && por_seq |-> por_cnt >= 11'h208 && por_cnt <= 11'h20d)
        else $error("power-on release delay wrong");
endmodule
bind rss_reset_source_sequencer rss_asserts u_chk (.aclk, .aresetn, .power_on_reset_n,
    .hard_reset_n_oe, .pll_reset, .watchdog_regs_reset, .core_reset, .soft_reset_n,
    .scan_cmd, .captured_straps);
`default_nettype wire

// ===== verification/rss_board.sv
// Purpose: Board reset circuit and strap pins
// Assumes: Hard reset wire has a pull-up
// Notes:   Power-on low is stretched past its minimum
`timescale 1ns/1ps
`default_nettype none
module rss_board (
    // Bench control
    input  wire logic                 aclk,
    input  wire logic                 por_req,
    input  wire logic                 pull_req,
    input  wire rss_pkg::rss_straps_t strap_val,
    // Device pins
    input  wire logic                 hard_reset_n_out,
    input  wire logic                 hard_reset_n_oe,
    output logic                      power_on_reset_n,
    output logic                      hard_reset_n_in,
    output rss_pkg::rss_straps_t      straps
);
    import rss_pkg::*;
    int low_cnt = 0;
    always @(posedge aclk) low_cnt <= por_req ? POR_MIN_CYCLES + 8 : low_cnt - (low_cnt > 0);
    assign power_on_reset_n = !por_req && low_cnt == 0;
    // Open drain: any low driver wins, else the pull-up
    assign hard_reset_n_in = !(hard_reset_n_oe && !hard_reset_n_out) && !pull_req;
    assign straps = strap_val;
endmodule
`default_nettype wire

// ===== verification/rss_reset_source_sequencer_tb.sv
// Purpose: Self-checking bench for the reset source sequencer
// Assumes: Default scan codes; board model drives the pins
// Notes:   Windows allow for the pin synchronisers
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin checked++; if ((a) !== (e)) begin miscompares++; \
    $display("unexpected %s exp %h got %h", nm, e, a); end end
module rss_reset_source_sequencer_tb;
    import rss_pkg::*;
    typedef struct packed {
        logic        w;
        logic [3:0]  a;
        logic [31:0] d;
        logic [31:0] q;
        logic [1:0]  r;
    } rss_row_t;
    logic        aclk = 1'b0, aresetn = 1'b0, watchdog_expired = 1'b0, pull_req = 1'b0;
    logic        bus_monitor_timeout = 1'b0, por_req = 1'b1, s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0, power_on_reset_n, hard_reset_n_in, hard_reset_n_out;
    logic        hard_reset_n_oe, pll_reset, watchdog_regs_reset, clock_ctrl_reset;
    logic        core_reset, periph_reset, soft_reset_n, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, q;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    rss_scan_t   scan_cmd = '0;
    rss_straps_t strap_val = 5'h15, straps, captured_straps;
    int          checked = 0, miscompares = 0, n;
    rss_row_t    rows [7] = '{'{1'b0, ADDR_CTRL, 32'h0, 32'h0, RESP_OKAY},
        '{1'b0, ADDR_STATUS, 32'h0, 32'h0, RESP_OKAY},
        '{1'b0, ADDR_CONFIG, 32'h0, 32'h15, RESP_OKAY}, '{1'b0, 4'h6, 32'h0, 32'h0, RESP_SLVERR},
        '{1'b1, ADDR_STATUS, 32'hf, 32'h0, RESP_OKAY}, '{1'b1, 4'h2, 32'h1, 32'h0, RESP_SLVERR},
        '{1'b1, ADDR_CTRL, 32'h0, 32'h0, RESP_OKAY}};
    rss_reset_source_sequencer dut (.aclk, .aresetn, .power_on_reset_n, .hard_reset_n_in,
        .hard_reset_n_out, .hard_reset_n_oe, .watchdog_expired, .bus_monitor_timeout,
        .scan_cmd, .straps, .pll_reset, .watchdog_regs_reset, .clock_ctrl_reset, .core_reset,
        .periph_reset, .soft_reset_n, .captured_straps, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    rss_board board (.aclk, .por_req, .pull_req, .strap_val, .hard_reset_n_out,
        .hard_reset_n_oe, .power_on_reset_n, .hard_reset_n_in, .straps);
    always #12.5 aclk = ~aclk;
    task report_and_stop;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic wait_lvl(input logic s, input logic v);
        n = 0;
        while ((s ? hard_reset_n_oe : power_on_reset_n) !== v && n < 2000) begin
            @(posedge aclk);
            n++;
        end
        if (n >= 2000) begin
            miscompares++;
            report_and_stop();
        end
    endtask
    task automatic axi(input logic w, input logic [3:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_bready <= w;
        s_axi_arvalid <= !w;
        s_axi_rready <= !w;
        do begin
            @(posedge aclk);
            k++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            q = s_axi_rdata;
            r = w ? s_axi_bresp : s_axi_rresp;
        end while (!(w ? s_axi_bvalid : s_axi_rvalid) && k < 200);
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        if (!(w ? s_axi_bvalid : s_axi_rvalid)) begin
            miscompares++;
            report_and_stop();
        end
    endtask
    task automatic por_tail;
        wait_lvl(1'b0, 1'b1);
        wait_lvl(1'b1, 1'b0);
        `CHK("por_release", 1'b1, n >= 521 && n <= 525)
        `CHK("captured_straps", strap_val, captured_straps)
        `CHK("pll_after", 1'b0, pll_reset)
    endtask
    initial begin
        repeat (20) @(posedge aclk);
        `CHK("pll_in_reset", 1'b1, pll_reset)
        aresetn <= 1'b1;
        por_req <= 1'b0;
        por_tail();
        foreach (rows[j]) begin
            axi(rows[j].w, rows[j].a, rows[j].d);
            `CHK("resp", rows[j].r, r)
            if (!rows[j].w) `CHK("rdata", rows[j].q, q)
        end
        `CHK("no_request", 1'b0, hard_reset_n_oe)
        strap_val <= 5'h0a;
        for (int k = 0; k < 4; k++) begin
            watchdog_expired <= (k == 0);
            bus_monitor_timeout <= (k == 1);
            pull_req <= (k == 2);
            if (k == 3) axi(1'b1, ADDR_CTRL, 32'h1);
            @(posedge aclk);
            watchdog_expired <= 1'b0;
            bus_monitor_timeout <= 1'b0;
            pull_req <= 1'b0;
            wait_lvl(1'b1, 1'b1);
            `CHK("pin_low", 1'b0, hard_reset_n_in)
            `CHK("pll_kept", 1'b0, pll_reset)
            `CHK("blocks", 1'b1, core_reset & periph_reset & clock_ctrl_reset)
            `CHK("wdog_regs", 1'b1, watchdog_regs_reset)
            wait_lvl(1'b1, 1'b0);
            `CHK("hard_len", 1'b1, n >= 516 && n <= 524)
            `CHK("straps_kept", 5'h15, captured_straps)
        end
        for (int i = 0; i < 5; i++) begin
            if (i < 4) scan_cmd <= '{i[2:0], 1'b1};
            else axi(1'b1, ADDR_CTRL, 32'h2);
            @(posedge aclk);
            scan_cmd <= '0;
            repeat (3) @(posedge aclk);
            `CHK("soft_reset_n", i == 3, soft_reset_n)
            `CHK("soft_pin", 1'b0, hard_reset_n_oe)
            `CHK("soft_core", i != 3, core_reset & periph_reset)
            `CHK("soft_wdog", i != 3, watchdog_regs_reset)
            `CHK("soft_pll", 1'b0, pll_reset)
            repeat (20) @(posedge aclk);
        end
        axi(1'b0, ADDR_COUNT, 32'h0);
        `CHK("event_count", 32'h0020_2000, q)
        por_req <= 1'b1;
        @(posedge aclk);
        por_req <= 1'b0;
        repeat (8) @(posedge aclk);
        `CHK("por_pll", 1'b1, pll_reset)
        por_tail();
        report_and_stop();
    end
endmodule
`default_nettype wire
